// File: sacfg_axis.sv
/*
 Stepper axis configuration: parameter store, mode selection, limit handling,
 chopper off timer and current taper timer.
 Assumes a host presents numbered parameter writes and reads, synchronous to clk.
*/
// Summary of operation
// - Load-adaptive current off above speed threshold
// - Hold minimum speed for load commutation
// - Right limit inverted when bit set
// - Left limit inverted when bit set
// - Soft stop ramps down on limit
// - Alternate chopper above threshold when enabled
// - Fullstep above threshold when enabled
// - Read-only measured driver speed
// - Current taper in 0.16384 s steps
// - Ten-bit load commutation pulse width
// - Eight-bit stall sensitivity setting
// - Relative move origin: target or actual
// - Microstep code gives two-power resolution
// - Interpolate to 256 at 16 microsteps
// - Double stepping steps on both step edges
// - Select hysteresis or constant off-time chopper
// - Disable fast decay comparator option
// - Four-bit hysteresis end or decay time
// - Hysteresis start or sine offset, 0..8
// - Off period 12+32n, min 64, 0 freewheels
// - Adaptive floor one half or quarter
// - Readings per decrement 32, 8, 2, 1
`timescale 1ns/1ps
`include "sacfg_map.svh"
module sacfg_axis #(
	parameter int TAPER_UNIT_CYC = int'(`SACFG_TAPER_UNIT_NS / `SACFG_CLK_NS)
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] param_num,
	input wire logic [31:0] wr_data,
	output logic [31:0] rd_data,
	output logic rd_valid,
	output logic wr_reject,
	input wire logic [22:0] measured_speed,
	input wire logic right_limit_raw,
	input wire logic left_limit_raw,
	input wire logic motion_stopped,
	output logic right_limit_r,
	output logic left_limit_r,
	output logic limit_stop_soft,
	output logic limit_stop_hard,
	output logic adaptive_current_on,
	output logic load_commutation_on,
	output logic alt_chopper_on,
	output logic fullstep_on,
	output logic [8:0] substeps_per_full,
	output logic interp_active,
	output logic step_both_edges,
	output logic move_from_actual,
	output logic chop_phase_on,
	output logic drivers_off,
	output logic [4:0] hyst_total,
	output logic [3:0] decay_time,
	output logic [3:0] sine_offset,
	output logic decay_comp_used,
	output logic [1:0] blank_sel,
	output logic [9:0] dc_pulse_width,
	output logic [7:0] dc_stall_sense,
	output logic adaptive_floor_select,
	output logic [5:0] readings_per_decrement,
	output logic taper_active,
	output logic current_powered_down
);
	logic [22:0] speed_thr_r, dc_min_r, meas_r;
	logic rlim_inv_r, llim_inv_r, soft_r, hs_chop_r, hs_full_r, rel_org_r, interp_r, dbl_r;
	logic scheme_r, dcmp_dis_r, floor_r;
	logic [3:0] taper_r, ustep_r, hend_r, hstrt_r, off_time_setting_r;
	logic [9:0] dctime_r;
	logic [7:0] dcstall_r;
	logic [1:0] blank_r, down_r;
	logic range_ok;
	logic [31:0] rd_nxt;

	// Range check on write
	always_comb
	begin
		range_ok = 1'b1;
		unique case (param_num)
			`SACFG_SPEED_THR, `SACFG_DC_MIN: range_ok = wr_data <= 32'(`SACFG_SPEED_MAX);
			`SACFG_RLIM_INV, `SACFG_LLIM_INV, `SACFG_SOFT, `SACFG_HS_CHOP, `SACFG_HS_FULL, `SACFG_REL_ORG,
			`SACFG_INTERP, `SACFG_DBL, `SACFG_SCHEME, `SACFG_DCMP_DIS, `SACFG_FLOOR: range_ok = wr_data <= 32'h1;
			`SACFG_TAPER, `SACFG_HEND, `SACFG_OFF_TIME: range_ok = wr_data <= 32'hF;
			`SACFG_DC_TIME: range_ok = wr_data <= 32'h3FF;
			`SACFG_DC_STALL: range_ok = wr_data <= 32'hFF;
			`SACFG_USTEP: range_ok = wr_data <= 32'(`SACFG_USTEP_MAX);
			`SACFG_HSTRT: range_ok = wr_data <= 32'(`SACFG_HSTRT_MAX);
			`SACFG_BLANK, `SACFG_DOWN: range_ok = wr_data <= 32'h3;
			default:
			begin
				range_ok = 1'b0;
			end
		endcase
	end

	// Parameter store; reset values are a neutral choice
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			speed_thr_r <= '0; dc_min_r <= '0; rlim_inv_r <= 1'b0; llim_inv_r <= 1'b0;
			soft_r <= 1'b0; hs_chop_r <= 1'b0; hs_full_r <= 1'b0; taper_r <= '0;
			dctime_r <= '0; dcstall_r <= '0; rel_org_r <= 1'b0; ustep_r <= 4'h8;
			interp_r <= 1'b0; dbl_r <= 1'b0; blank_r <= 2'h2; scheme_r <= 1'b0;
			dcmp_dis_r <= 1'b0; hend_r <= '0; hstrt_r <= '0; off_time_setting_r <= 4'h3;
			floor_r <= 1'b0; down_r <= '0; wr_reject <= 1'b0;
		end
		else if (ce)
		begin
			wr_reject <= wr_en && !range_ok;
			if (wr_en && range_ok)
			begin
				unique case (param_num)
					`SACFG_SPEED_THR: speed_thr_r <= wr_data[22:0];
					`SACFG_DC_MIN: dc_min_r <= wr_data[22:0];
					`SACFG_RLIM_INV: rlim_inv_r <= wr_data[0];
					`SACFG_LLIM_INV: llim_inv_r <= wr_data[0];
					`SACFG_SOFT: soft_r <= wr_data[0];
					`SACFG_HS_CHOP: hs_chop_r <= wr_data[0];
					`SACFG_HS_FULL: hs_full_r <= wr_data[0];
					`SACFG_TAPER: taper_r <= wr_data[3:0];
					`SACFG_DC_TIME: dctime_r <= wr_data[9:0];
					`SACFG_DC_STALL: dcstall_r <= wr_data[7:0];
					`SACFG_REL_ORG: rel_org_r <= wr_data[0];
					`SACFG_USTEP: ustep_r <= wr_data[3:0];
					`SACFG_INTERP: interp_r <= wr_data[0];
					`SACFG_DBL: dbl_r <= wr_data[0];
					`SACFG_BLANK: blank_r <= wr_data[1:0];
					`SACFG_SCHEME: scheme_r <= wr_data[0];
					`SACFG_DCMP_DIS: dcmp_dis_r <= wr_data[0];
					`SACFG_HEND: hend_r <= wr_data[3:0];
					`SACFG_HSTRT: hstrt_r <= wr_data[3:0];
					`SACFG_OFF_TIME: off_time_setting_r <= wr_data[3:0];
					`SACFG_FLOOR: floor_r <= wr_data[0];
					`SACFG_DOWN: down_r <= wr_data[1:0];
					default: ;
				endcase
			end
		end
	end

	// Readback, one cycle after rd_en
	always_comb
	begin
		unique case (param_num)
			`SACFG_SPEED_THR: rd_nxt = {9'h0, speed_thr_r};
			`SACFG_DC_MIN: rd_nxt = {9'h0, dc_min_r};
			`SACFG_RLIM_INV: rd_nxt = {31'h0, rlim_inv_r};
			`SACFG_LLIM_INV: rd_nxt = {31'h0, llim_inv_r};
			`SACFG_SOFT: rd_nxt = {31'h0, soft_r};
			`SACFG_HS_CHOP: rd_nxt = {31'h0, hs_chop_r};
			`SACFG_HS_FULL: rd_nxt = {31'h0, hs_full_r};
			`SACFG_MEAS: rd_nxt = {9'h0, meas_r};
			`SACFG_TAPER: rd_nxt = {28'h0, taper_r};
			`SACFG_DC_TIME: rd_nxt = {22'h0, dctime_r};
			`SACFG_DC_STALL: rd_nxt = {24'h0, dcstall_r};
			`SACFG_REL_ORG: rd_nxt = {31'h0, rel_org_r};
			`SACFG_USTEP: rd_nxt = {28'h0, ustep_r};
			`SACFG_INTERP: rd_nxt = {31'h0, interp_r};
			`SACFG_DBL: rd_nxt = {31'h0, dbl_r};
			`SACFG_BLANK: rd_nxt = {30'h0, blank_r};
			`SACFG_SCHEME: rd_nxt = {31'h0, scheme_r};
			`SACFG_DCMP_DIS: rd_nxt = {31'h0, dcmp_dis_r};
			`SACFG_HEND: rd_nxt = {28'h0, hend_r};
			`SACFG_HSTRT: rd_nxt = {28'h0, hstrt_r};
			`SACFG_OFF_TIME: rd_nxt = {28'h0, off_time_setting_r};
			`SACFG_FLOOR: rd_nxt = {31'h0, floor_r};
			`SACFG_DOWN: rd_nxt = {30'h0, down_r};
			default: rd_nxt = 32'h0;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rd_data <= '0;
			rd_valid <= 1'b0;
		end
		else if (ce)
		begin
			rd_valid <= rd_en;
			if (rd_en)
				rd_data <= rd_nxt;
		end
	end

	// Speed-dependent modes; speed above max clamps, since the driver never reports more
	logic above_thr;
	assign above_thr = meas_r > speed_thr_r;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meas_r <= '0; adaptive_current_on <= 1'b0; load_commutation_on <= 1'b0;
			alt_chopper_on <= 1'b0; fullstep_on <= 1'b0;
		end
		else if (ce)
		begin
			meas_r <= (measured_speed > `SACFG_SPEED_MAX) ? `SACFG_SPEED_MAX : measured_speed;
			adaptive_current_on <= !above_thr;
			load_commutation_on <= meas_r >= dc_min_r;
			alt_chopper_on <= hs_chop_r && above_thr;
			fullstep_on <= hs_full_r && above_thr;
		end
	end

	// Limits and static decodes
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			right_limit_r <= 1'b0; left_limit_r <= 1'b0; limit_stop_soft <= 1'b0; limit_stop_hard <= 1'b0;
			substeps_per_full <= '0; interp_active <= 1'b0; step_both_edges <= 1'b0; move_from_actual <= 1'b0;
			hyst_total <= '0; decay_time <= '0; sine_offset <= '0; decay_comp_used <= 1'b0; blank_sel <= '0;
			dc_pulse_width <= '0; dc_stall_sense <= '0; adaptive_floor_select <= 1'b0; readings_per_decrement <= '0;
		end
		else if (ce)
		begin
			right_limit_r <= right_limit_raw ^ rlim_inv_r;
			left_limit_r <= left_limit_raw ^ llim_inv_r;
			limit_stop_soft <= (right_limit_r || left_limit_r) && soft_r;
			limit_stop_hard <= (right_limit_r || left_limit_r) && !soft_r;
			substeps_per_full <= 9'h1 << ustep_r;
			interp_active <= interp_r && (ustep_r == `SACFG_USTEP_INTERP);
			step_both_edges <= dbl_r;
			move_from_actual <= rel_org_r;
			hyst_total <= scheme_r ? 5'h0 : 5'(hend_r) + 5'(hstrt_r);
			decay_time <= scheme_r ? hend_r : 4'h0;
			sine_offset <= scheme_r ? hstrt_r : 4'h0;
			decay_comp_used <= !(scheme_r && dcmp_dis_r);
			blank_sel <= blank_r;
			dc_pulse_width <= dctime_r;
			dc_stall_sense <= dcstall_r;
			adaptive_floor_select <= floor_r;
			unique case (down_r)
				2'h0: readings_per_decrement <= 6'h20;
				2'h1: readings_per_decrement <= 6'h08;
				2'h2: readings_per_decrement <= 6'h02;
				2'h3: readings_per_decrement <= 6'h01;
			endcase
		end
	end

	// Chopper off-phase timer
	logic [9:0] off_len, off_cnt_r;
	always_comb
	begin
		off_len = `SACFG_OFF_BASE + `SACFG_OFF_MUL * 10'(off_time_setting_r);
		if (off_len < `SACFG_OFF_MIN)
			off_len = `SACFG_OFF_MIN;
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			off_cnt_r <= '0; chop_phase_on <= 1'b0; drivers_off <= 1'b1;
		end
		else if (ce)
		begin
			drivers_off <= off_time_setting_r == 4'h0;
			if (off_time_setting_r == 4'h0)
			begin
				off_cnt_r <= '0;
				chop_phase_on <= 1'b0;
			end
			else if (off_cnt_r >= off_len - 10'd1)
			begin
				off_cnt_r <= '0;
				chop_phase_on <= !chop_phase_on;
			end
			else
				off_cnt_r <= off_cnt_r + 10'd1;
		end
	end

	// Power-down taper
	sacfg_pkg::sacfg_pd_t pd_r;
	logic [31:0] unit_cnt_r;
	logic [3:0] taper_left_r;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pd_r <= sacfg_pkg::SACFG_IDLE; unit_cnt_r <= '0; taper_left_r <= '0;
			taper_active <= 1'b0; current_powered_down <= 1'b0;
		end
		else if (ce)
		begin
			unique case (pd_r)
				sacfg_pkg::SACFG_IDLE:
					if (motion_stopped)
					begin
						unit_cnt_r <= '0;
						taper_left_r <= taper_r;
						pd_r <= (taper_r == 4'h0) ? sacfg_pkg::SACFG_DOWN : sacfg_pkg::SACFG_TAPER;
						taper_active <= taper_r != 4'h0;
						current_powered_down <= taper_r == 4'h0;
					end
				sacfg_pkg::SACFG_TAPER:
					if (!motion_stopped)
					begin
						pd_r <= sacfg_pkg::SACFG_IDLE;
						taper_active <= 1'b0;
					end
					else if (unit_cnt_r == 32'(TAPER_UNIT_CYC - 1))
					begin
						unit_cnt_r <= '0;
						taper_left_r <= taper_left_r - 4'h1;
						if (taper_left_r == 4'h1)
						begin
							pd_r <= sacfg_pkg::SACFG_DOWN;
							taper_active <= 1'b0;
							current_powered_down <= 1'b1;
						end
					end
					else
						unit_cnt_r <= unit_cnt_r + 32'h1;
				sacfg_pkg::SACFG_DOWN:
					if (!motion_stopped)
					begin
						pd_r <= sacfg_pkg::SACFG_IDLE;
						current_powered_down <= 1'b0;
					end
			endcase
		end
	end

	mode_above_a: assert property (@(posedge clk) disable iff (rst)
		ce && hs_full_r && $stable(hs_full_r) && (meas_r > speed_thr_r) && $stable(speed_thr_r) ##1 ce
		|-> fullstep_on) else $error("fullstep not engaged above threshold");
	chop_alt_a: assert property (@(posedge clk) disable iff (rst)
		ce && !hs_chop_r ##1 ce |-> !alt_chopper_on) else $error("alternate chopper without enable");
	adapt_off_a: assert property (@(posedge clk) disable iff (rst)
		ce && (meas_r > speed_thr_r) ##1 ce |-> !adaptive_current_on) else $error("adaptive current above threshold");
	limit_inv_a: assert property (@(posedge clk) disable iff (rst)
		ce |=> !ce || (right_limit_r == ($past(right_limit_raw) ^ $past(rlim_inv_r)))) else $error("right limit polarity");
	left_inv_a: assert property (@(posedge clk) disable iff (rst)
		ce |=> !ce || (left_limit_r == ($past(left_limit_raw) ^ $past(llim_inv_r)))) else $error("left limit polarity");
	reject_keep_a: assert property (@(posedge clk) disable iff (rst)
		ce && wr_en && param_num == `SACFG_OFF_TIME && wr_data > 32'hF |=> wr_reject && $stable(off_time_setting_r))
		else $error("out-of-range write stored");
	off_zero_a: assert property (@(posedge clk) disable iff (rst)
		ce && off_time_setting_r == 4'h0 ##1 ce |-> drivers_off ##1 !chop_phase_on)
		else $error("zero off time not freewheeling");
	// Compare against the code in force one edge earlier; a write may land in between
	ustep_dec_a: assert property (@(posedge clk) disable iff (rst)
		ce ##1 ce |-> substeps_per_full == (9'h1 << $past(ustep_r))) else $error("microstep decode");
	instant_pd_a: assert property (@(posedge clk) disable iff (rst)
		ce && pd_r == sacfg_pkg::SACFG_IDLE && motion_stopped && taper_r == 4'h0 |=> current_powered_down)
		else $error("instant power down missing");
	interp_only_a: assert property (@(posedge clk) disable iff (rst)
		ce && ustep_r != `SACFG_USTEP_INTERP && $stable(ustep_r) ##1 ce |-> !interp_active)
		else $error("interpolation outside 16 microsteps");
	soft_halt_a: assert property (@(posedge clk) disable iff (rst)
		ce ##1 ce |-> limit_stop_soft == (($past(right_limit_r) || $past(left_limit_r)) && $past(soft_r)))
		else $error("soft stop selection");
	meas_only_a: assert property (@(posedge clk) disable iff (rst)
		ce && wr_en && param_num == `SACFG_MEAS |=> wr_reject) else $error("write to measured speed accepted");
	edge_twice_a: assert property (@(posedge clk) disable iff (rst)
		ce ##1 ce |-> step_both_edges == $past(dbl_r)) else $error("double step select");
	floor_sel_a: assert property (@(posedge clk) disable iff (rst)
		ce ##1 ce |-> adaptive_floor_select == $past(floor_r)) else $error("adaptive floor select");
	origin_sel_a: assert property (@(posedge clk) disable iff (rst)
		ce ##1 ce |-> move_from_actual == $past(rel_org_r)) else $error("relative move origin");
endmodule // sacfg_axis

// File: sacfg_map.svh
/*
 Register numbers, field widths and timing counts for the stepper axis configuration block.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef SACFG_MAP_SVH
`define SACFG_MAP_SVH
`define SACFG_SPEED_THR 8'h16
`define SACFG_DC_MIN 8'h17
`define SACFG_RLIM_INV 8'h18
`define SACFG_LLIM_INV 8'h19
`define SACFG_SOFT 8'h1A
`define SACFG_HS_CHOP 8'h1B
`define SACFG_HS_FULL 8'h1C
`define SACFG_MEAS 8'h1D
`define SACFG_TAPER 8'h1F
`define SACFG_DC_TIME 8'h20
`define SACFG_DC_STALL 8'h21
`define SACFG_REL_ORG 8'h7F
`define SACFG_USTEP 8'h8C
`define SACFG_INTERP 8'hA0
`define SACFG_DBL 8'hA1
`define SACFG_BLANK 8'hA2
`define SACFG_SCHEME 8'hA3
`define SACFG_DCMP_DIS 8'hA4
`define SACFG_HEND 8'hA5
`define SACFG_HSTRT 8'hA6
`define SACFG_OFF_TIME 8'hA7
`define SACFG_FLOOR 8'hA8
`define SACFG_DOWN 8'hA9
`define SACFG_SPEED_MAX 23'd7999774
`define SACFG_USTEP_MAX 4'h8
`define SACFG_HSTRT_MAX 4'h8
`define SACFG_USTEP_INTERP 4'h4
`define SACFG_OFF_BASE 10'd12
`define SACFG_OFF_MUL 10'd32
`define SACFG_OFF_MIN 10'd64
`define SACFG_TAPER_UNIT_NS 64'd163840000
`define SACFG_CLK_NS 64'd5
`endif

// File: sacfg_pkg.sv
/*
 Types for the stepper axis configuration block.
 Assumes nothing beyond the compile order.
*/
package sacfg_pkg;
	typedef enum logic [1:0] {SACFG_IDLE, SACFG_TAPER, SACFG_DOWN} sacfg_pd_t;
endpackage

// File: sacfg_motor_model.sv
/*
 Far-side model: driver speed report, raw limit switch levels and the at-rest flag.
 Assumes the bench calls its tasks from its own process; outputs move on falling edges.
*/
`timescale 1ns/1ps
`include "sacfg_map.svh"
module sacfg_motor_model (
	input wire logic clk,
	output logic [22:0] measured_speed,
	output logic right_limit_raw,
	output logic left_limit_raw,
	output logic motion_stopped
);
	initial
	begin
		measured_speed = 23'h000000;
		right_limit_raw = 1'b0;
		left_limit_raw = 1'b0;
		motion_stopped = 1'b0;
	end
	// Real driver never reports beyond its range
	task automatic set_speed(input logic [22:0] v);
		@(negedge clk);
		measured_speed = (v > `SACFG_SPEED_MAX) ? `SACFG_SPEED_MAX : v;
	endtask
	task automatic set_pins(input logic r, input logic l, input logic stopped);
		@(negedge clk);
		right_limit_raw = r;
		left_limit_raw = l;
		motion_stopped = stopped;
	endtask
endmodule // sacfg_motor_model

// File: sacfg_axis_bench.sv
/*
 Bench for the axis configuration block: parameter access, mode selection, limits, chopper and taper.
 Assumes the map header, package, design and motor model are compiled first.
*/
`timescale 1ns/1ps
`include "sacfg_map.svh"
module sacfg_axis_bench;
	localparam int UNIT = 10;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] param_num = 8'h00;
	logic [31:0] wr_data = 32'h00000000;
	logic [31:0] rd_data, val;
	logic [22:0] measured_speed;
	logic rd_valid, wr_reject, right_limit_raw, left_limit_raw, motion_stopped, right_limit_r, left_limit_r;
	logic limit_stop_soft, limit_stop_hard, adaptive_current_on, load_commutation_on, alt_chopper_on, fullstep_on;
	logic interp_active, step_both_edges, move_from_actual, chop_phase_on, drivers_off, decay_comp_used;
	logic adaptive_floor_select, taper_active, current_powered_down, rej;
	logic [8:0] substeps_per_full;
	logic [4:0] hyst_total;
	logic [3:0] decay_time, sine_offset;
	logic [1:0] blank_sel;
	logic [9:0] dc_pulse_width;
	logic [7:0] dc_stall_sense;
	logic [5:0] readings_per_decrement;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;
	int n;

	sacfg_axis #(.TAPER_UNIT_CYC(UNIT)) dut (.clk(clk), .rst(rst), .ce(ce), .wr_en(wr_en), .rd_en(rd_en),
		.param_num(param_num), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .wr_reject(wr_reject),
		.measured_speed(measured_speed), .right_limit_raw(right_limit_raw), .left_limit_raw(left_limit_raw),
		.motion_stopped(motion_stopped), .right_limit_r(right_limit_r), .left_limit_r(left_limit_r),
		.limit_stop_soft(limit_stop_soft), .limit_stop_hard(limit_stop_hard), .fullstep_on(fullstep_on),
		.adaptive_current_on(adaptive_current_on), .load_commutation_on(load_commutation_on),
		.alt_chopper_on(alt_chopper_on), .substeps_per_full(substeps_per_full), .interp_active(interp_active),
		.step_both_edges(step_both_edges), .move_from_actual(move_from_actual), .chop_phase_on(chop_phase_on),
		.drivers_off(drivers_off), .hyst_total(hyst_total), .decay_time(decay_time), .sine_offset(sine_offset),
		.decay_comp_used(decay_comp_used), .blank_sel(blank_sel), .dc_pulse_width(dc_pulse_width),
		.dc_stall_sense(dc_stall_sense), .adaptive_floor_select(adaptive_floor_select),
		.readings_per_decrement(readings_per_decrement), .taper_active(taper_active),
		.current_powered_down(current_powered_down));
	sacfg_motor_model motor (.clk(clk), .measured_speed(measured_speed), .right_limit_raw(right_limit_raw),
		.left_limit_raw(left_limit_raw), .motion_stopped(motion_stopped));

	always #2.5 clk = ~clk;

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Generous ceiling: whole sequence needs under a thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			$display("MISMATCH t=%0t run hung", $time);
			final_report();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Trailing wait also covers the extra edge for derived outputs
	task automatic wr(input logic [7:0] num, input logic [31:0] d);
		@(negedge clk);
		param_num = num;
		wr_data = d;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
		rej = wr_reject;
		repeat (3) @(negedge clk)
			rej = rej | wr_reject;
	endtask

	task automatic rdchk(input logic [7:0] num, input logic [31:0] exp);
		@(negedge clk);
		param_num = num;
		rd_en = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
		n = 0;
		while (rd_valid !== 1'b1 && n < 4)
		begin
			@(negedge clk);
			n++;
		end
		chk(n < 4, 1'b1);
		chk(rd_data, exp);
	endtask

	task automatic t_access();
		rdchk(`SACFG_USTEP, 32'h8);
		rdchk(`SACFG_OFF_TIME, 32'h3);
		chk(blank_sel, 2'h2);
		wr(`SACFG_OFF_TIME, 32'h5);
		chk(rej, 1'b0);
		rdchk(`SACFG_OFF_TIME, 32'h5);
		wr(`SACFG_USTEP, 32'h9);
		chk(rej, 1'b1);
		rdchk(`SACFG_USTEP, 32'h8);
		wr(`SACFG_HSTRT, 32'h9);
		chk(rej, 1'b1);
		wr(`SACFG_SPEED_THR, 32'h007A111F);
		chk(rej, 1'b1);
		wr(`SACFG_SPEED_THR, 32'h007A111E);
		chk(rej, 1'b0);
		wr(`SACFG_MEAS, 32'h1);
		chk(rej, 1'b1);
		rdchk(8'h00, 32'h0);
		wr(`SACFG_DC_TIME, 32'h3FF);
		wr(`SACFG_DC_TIME, 32'h400);
		chk(rej, 1'b1);
		chk(dc_pulse_width, 10'h3FF);
		wr(`SACFG_DC_STALL, 32'hFF);
		chk(dc_stall_sense, 8'hFF);
	endtask

	task automatic t_step();
		for (int c = 0; c <= 8; c++)
		begin
			wr(`SACFG_USTEP, c);
			chk(substeps_per_full, 32'h1 << c);
		end
		wr(`SACFG_INTERP, 32'h1);
		chk(interp_active, 1'b0);
		wr(`SACFG_USTEP, 32'h4);
		chk(interp_active, 1'b1);
		wr(`SACFG_DBL, 32'h1);
		chk(step_both_edges, 1'b1);
		wr(`SACFG_REL_ORG, 32'h1);
		chk(move_from_actual, 1'b1);
	endtask

	task automatic t_speed();
		wr(`SACFG_SPEED_THR, 32'd1000);
		wr(`SACFG_DC_MIN, 32'd500);
		wr(`SACFG_HS_CHOP, 32'h1);
		wr(`SACFG_HS_FULL, 32'h1);
		motor.set_speed(23'd1001);
		repeat (4) @(negedge clk);
		chk({alt_chopper_on, fullstep_on}, 2'h3);
		chk({adaptive_current_on, load_commutation_on}, 2'h1);
		motor.set_speed(23'd1000);
		repeat (4) @(negedge clk);
		chk({alt_chopper_on, fullstep_on, adaptive_current_on}, 3'h1);
		motor.set_speed(23'd499);
		repeat (4) @(negedge clk);
		chk(load_commutation_on, 1'b0);
		wr(`SACFG_HS_CHOP, 32'h0);
		motor.set_speed(23'd2000);
		repeat (4) @(negedge clk);
		chk({alt_chopper_on, fullstep_on}, 2'h1);
		rdchk(`SACFG_MEAS, 32'd2000);
	endtask

	task automatic t_limit();
		wr(`SACFG_RLIM_INV, 32'h1);
		motor.set_pins(1'b0, 1'b0, 1'b0);
		wr(`SACFG_SOFT, 32'h1);
		chk({right_limit_r, left_limit_r}, 2'h2);
		chk({limit_stop_soft, limit_stop_hard}, 2'h2);
		wr(`SACFG_SOFT, 32'h0);
		chk({limit_stop_soft, limit_stop_hard}, 2'h1);
		wr(`SACFG_LLIM_INV, 32'h1);
		motor.set_pins(1'b1, 1'b1, 1'b0);
		repeat (3) @(negedge clk);
		chk({right_limit_r, left_limit_r, limit_stop_hard}, 3'h0);
	endtask

	task automatic t_chop();
		logic p;
		wr(`SACFG_OFF_TIME, 32'h0);
		chk(drivers_off, 1'b1);
		for (int t = 1; t <= 2; t++)
		begin
			wr(`SACFG_OFF_TIME, t);
			chk(drivers_off, 1'b0);
			repeat (2)
			begin
				p = chop_phase_on;
				n = 0;
				while (chop_phase_on === p && n < 300)
				begin
					@(negedge clk);
					n++;
				end
			end
			chk(n, t == 1 ? 64 : 76);
		end
		wr(`SACFG_HEND, 32'h3);
		wr(`SACFG_HSTRT, 32'h8);
		wr(`SACFG_SCHEME, 32'h0);
		chk({hyst_total, decay_time}, {5'd11, 4'h0});
		wr(`SACFG_SCHEME, 32'h1);
		chk({hyst_total, decay_time, sine_offset, decay_comp_used}, {5'd0, 4'h3, 4'h8, 1'b1});
		wr(`SACFG_DCMP_DIS, 32'h1);
		chk(decay_comp_used, 1'b0);
	endtask

	task automatic t_adapt();
		logic [5:0] exp_cnt [4] = '{6'd32, 6'd8, 6'd2, 6'd1};
		for (int d = 0; d < 4; d++)
		begin
			wr(`SACFG_DOWN, d);
			chk(readings_per_decrement, exp_cnt[d]);
		end
		wr(`SACFG_FLOOR, 32'h1);
		chk(adaptive_floor_select, 1'b1);
		wr(`SACFG_FLOOR, 32'h0);
		chk(adaptive_floor_select, 1'b0);
	endtask

	// Enable low: a write is ignored and the chopper timer stops
	task automatic t_hold();
		logic p;
		@(negedge clk);
		ce = 1'b0;
		p = chop_phase_on;
		wr(`SACFG_DOWN, 32'h0);
		repeat (80) @(negedge clk);
		chk(chop_phase_on, p);
		chk(readings_per_decrement, 6'd1);
		ce = 1'b1;
		repeat (3) @(negedge clk);
		chk(readings_per_decrement, 6'd1);
	endtask

	task automatic t_taper();
		wr(`SACFG_TAPER, 32'h2);
		motor.set_pins(1'b1, 1'b1, 1'b1);
		n = 0;
		while (current_powered_down !== 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
			if (n == 5)
				chk(taper_active, 1'b1);
		end
		chk(n >= 2 * UNIT - 1 && n <= 2 * UNIT + 4, 1'b1);
		motor.set_pins(1'b1, 1'b1, 1'b0);
		wr(`SACFG_TAPER, 32'h0);
		chk(current_powered_down, 1'b0);
		motor.set_pins(1'b1, 1'b1, 1'b1);
		repeat (3) @(negedge clk);
		chk(current_powered_down, 1'b1);
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		chk(substeps_per_full, 9'h100);
		t_access();
		t_step();
		t_speed();
		t_limit();
		t_chop();
		t_adapt();
		t_hold();
		t_taper();
		final_report();
	end
endmodule // sacfg_axis_bench
